// File: hw/eic_pkg.sv
// Shared constants and types of the EEPROM I2C master controller
package eic_pkg;
	// Clock rate and bus timing figures
	localparam int CLK_MHZ = 125;
	localparam int T_LOW_NS = 4700;
	localparam int T_HIGH_NS = 4000;
	localparam int T_BUF_NS = 4700;
	localparam int T_HOLD_NS = 300;
	localparam int T_IDLE_MS = 4;
	localparam int T_ACK_MS = 30;
	localparam int T_ARB_MS = 1920;
	// Cycle counts, least times rounded up
	localparam int unsigned LOW_CYC = (T_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned HIGH_CYC = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned BUF_CYC = (T_BUF_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned IDLE_CYC = T_IDLE_MS * CLK_MHZ * 1000;
	localparam int unsigned ACK_CYC = T_ACK_MS * CLK_MHZ * 1000;
	localparam int unsigned ARB_CYC = T_ARB_MS * CLK_MHZ * 1000;
	// Counter widths
	localparam int TW = 22;
	localparam int AW = 28;
	// Register byte offsets
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_DATA = 12'h004;
	localparam logic [11:0] OFS_HWCFG = 12'h008;
	localparam logic [11:0] OFS_RSTCTL = 12'h00C;
	// Field positions
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_CODE_LSB = 28;
	localparam int CMD_TOUT_BIT = 16;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int HW_READY_BIT = 0;
	localparam int HW_MGMT_BIT = 1;
	localparam int RST_DIG_BIT = 0;
	// Command codes
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h3;
	localparam logic [2:0] CMD_RELOAD = 3'h7;
	// Reset values
	localparam logic [2:0] CMD_RST = 3'h0;
	localparam logic MGMT_I2C_RST = 1'b1;
	// EEPROM control byte and content map
	localparam logic [3:0] CTRL_CODE = 4'hA;
	localparam logic [7:0] VALID_FLAG = 8'hA5;
	localparam logic [3:0] LD_VALID = 4'h0;
	localparam logic [3:0] LD_MAC_LAST = 4'h6;
	localparam logic [3:0] LD_STRAP_FLAG = 4'h7;
	localparam logic [3:0] LD_STRAP_FIRST = 4'h8;
	localparam logic [3:0] LD_STRAP_LAST = 4'hB;
	localparam logic [3:0] LD_LAST = 4'hD;
	// Bit counter values
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_CTRL_LAST = 4'h7;
	// Engine states
	typedef enum logic [3:0] {
		ST_IDLE, ST_WAIT_FREE, ST_ST_SETUP, ST_ST_HOLD, ST_BIT_LOW, ST_BIT_REL,
		ST_BIT_HIGH, ST_RS_LOW, ST_SP_LOW, ST_SP_REL, ST_SP_HIGH, ST_SP_END, ST_DONE
	} eic_state_e;
	// Byte phases of one EEPROM access
	typedef enum logic [2:0] {
		PH_ADDR_CTRL, PH_ADDR_HI, PH_ADDR_LO, PH_RD_CTRL, PH_RD_DATA, PH_WR_DATA,
		PH_POLL_CTRL, PH_STANDBY
	} eic_phase_e;
endpackage

// File: hw/eic_top.sv
// EEPROM I2C master controller with loader start and APB registers
//
// How it works
// (R1) Bus busy from START until 4.7us after STOP
// (R2) Busy after reset; free after tbuf or 4ms idle
// (R3) Non-I2C management mode frees bus at once
// (R4) Start transfers only while bus is free
// (R5) Follow other masters' clock low and high phases
// (R6) Lost arbitration: driven high, sampled low
// (R7) After loss, stop driving data immediately
// (R8) Host keeps off EEPROM while we use it
// (R9) Address phase loss: restart after bus free
// (R10) Poll loss: restart poll, keep 30ms timer
// (R11) Expired poll timer still gets final poll
// (R12) No arbitration win in 1.92s: timeout
// (R13) Commands read, write, reload; loader reads only
// (R14) Write: load data, then command with busy
// (R15) Read: command with busy; data after done
// (R16) Reload code with busy reruns loader
// (R17) Software leaves command alone while busy
// (R18) No EEPROM response within 30ms: timeout
// (R19) Loader starts on resets or reload; busy set
// (R20) Ready bit clear while loader runs
// (R21) Loader maps flag, MAC, straps, burst bytes; bytes 12 and 13 are read but not stored
// (R22) Invalid first byte: load straps, finish
// (R23) Control bytes start with code 1010b
// (R24) Loader owns controller; commands wait
// (R25) Clock and data inputs pass two flip-flops
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module eic_top #(
	parameter int unsigned IDLE_CYC_P = eic_pkg::IDLE_CYC,
	parameter int unsigned ACK_CYC_P = eic_pkg::ACK_CYC,
	parameter int unsigned ARB_CYC_P = eic_pkg::ARB_CYC
) (
	// Clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Open-drain EEPROM bus
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Strap and loader results
	input wire logic eeprom_size_strap,
	output logic [47:0] mac_addr,
	output logic [31:0] strap_bits,
	output logic strap_load
);
	import eic_pkg::*;

	localparam logic [TW-1:0] LOW_LIM = TW'(LOW_CYC);
	localparam logic [TW-1:0] HIGH_LIM = TW'(HIGH_CYC);
	localparam logic [TW-1:0] BUF_LIM = TW'(BUF_CYC);
	localparam logic [TW-1:0] HOLD_LIM = TW'(HOLD_CYC);
	localparam logic [TW-1:0] IDLE_LIM = TW'(IDLE_CYC_P);
	localparam logic [TW-1:0] ACK_LIM = TW'(ACK_CYC_P);
	localparam logic [AW-1:0] ARB_LIM = AW'(ARB_CYC_P);

	eic_state_e state_r, state_nxt;
	eic_phase_e phase_r, phase_nxt;
	logic [2:0] meta_r, sync_r;
	logic scl_d_r, sda_d_r;
	logic bus_busy_r, post_rst_r, stop_seen_r;
	logic [TW-1:0] free_cnt_r;
	logic [TW-1:0] cnt_r, cnt_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [8:0] rx_r, rx_nxt;
	logic sda_drv_r, sda_nxt, scl_drv_r;
	logic fail_r, fail_nxt;
	logic poll_rst, arb_rst, arb_won, job_end;
	logic arb_run_r;
	logic [AW-1:0] arb_cnt_r;
	logic [TW-1:0] poll_cnt_r;
	logic busy_r, tout_r, ld_active_r, dig_pend_r, mgmt_i2c_r;
	logic [2:0] cmd_r;
	logic [ADDR_W-1:0] addr_r, job_addr_r;
	logic [DATA_W-1:0] data_r;
	logic job_rd_r, two_byte_r;
	logic [3:0] ld_idx_r;
	logic [7:0] strap_flag_r;
	logic [47:0] mac_r;
	logic [31:0] strap_sh_r, strap_r;
	logic strap_load_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r;

	// Synchronised pin levels and edges
	wire scl_s = sync_r[2];
	wire sda_s = sync_r[1];
	wire size_s = sync_r[0];
	wire start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_w = scl_s & scl_d_r & ~sda_d_r & sda_s;
	wire free_hit_w = (stop_seen_r && free_cnt_r >= BUF_LIM) || (post_rst_r && free_cnt_r >= IDLE_LIM);

	// Byte to send in the current phase
	wire [2:0] sel_w = two_byte_r ? 3'h0 : job_addr_r[10:8];
	wire [7:0] ctrl_w_w = {CTRL_CODE, sel_w, 1'b0};
	wire [7:0] ctrl_r_w = {CTRL_CODE, sel_w, 1'b1};
	wire [7:0] poll_w = {CTRL_CODE, 3'h0, 1'b0};
	wire [7:0] tx_byte_w = (phase_r == PH_ADDR_CTRL) ? ctrl_w_w :
		(phase_r == PH_RD_CTRL) ? ctrl_r_w :
		(phase_r == PH_POLL_CTRL) ? poll_w :
		(phase_r == PH_ADDR_HI) ? job_addr_r[15:8] :
		(phase_r == PH_ADDR_LO) ? job_addr_r[7:0] : data_r;
	wire [2:0] bsel_w = 3'h7 - bit_r[2:0];
	wire tx_w = (bit_r < BIT_ACK) ? (phase_r != PH_RD_DATA) : (phase_r == PH_RD_DATA);
	wire tx_low_w = tx_w & (bit_r < BIT_ACK) & ~tx_byte_w[bsel_w];
	wire ctrl_ph_w = (phase_r == PH_ADDR_CTRL) || (phase_r == PH_POLL_CTRL);
	wire cmd_ok_w = (cmd_r == CMD_READ) || (cmd_r == CMD_WRITE);
	wire idle_w = (state_r == ST_IDLE) && !dig_pend_r;
	wire start_job_w = idle_w && busy_r && (ld_active_r || cmd_ok_w);

	// APB decode and read data
	wire acc_w = psel & penable & ~pready_r;
	wire wr_w = psel & penable & pready_r & pwrite;
	wire hit_cmd_w = paddr == OFS_CMD;
	wire hit_data_w = paddr == OFS_DATA;
	wire hit_hw_w = paddr == OFS_HWCFG;
	wire hit_rst_w = paddr == OFS_RSTCTL;
	wire mapped_w = hit_cmd_w | hit_data_w | hit_hw_w | hit_rst_w;
	wire [31:0] cmd_rd_w = {busy_r, cmd_r, {(CMD_CODE_LSB - CMD_TOUT_BIT - 1){1'b0}}, tout_r, addr_r};
	wire [31:0] data_rd_w = {{(32 - DATA_W){1'b0}}, data_r};
	wire [31:0] hw_rd_w = {{(32 - HW_MGMT_BIT - 1){1'b0}}, mgmt_i2c_r, ~ld_active_r}; // R20
	wire [31:0] rst_rd_w = {{(32 - RST_DIG_BIT - 1){1'b0}}, dig_pend_r};
	wire [31:0] rd_w = hit_cmd_w ? cmd_rd_w : hit_data_w ? data_rd_w :
		hit_hw_w ? hw_rd_w : hit_rst_w ? rst_rd_w : 32'h0000_0000;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_drv_r;
	assign sda_oe = sda_drv_r;
	assign mac_addr = mac_r;
	assign strap_bits = strap_r;
	assign strap_load = strap_load_r;

	// Two-stage synchronisers and edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 3'h7;
			sync_r <= 3'h7;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (ce) begin
			meta_r <= {scl_i, sda_i, eeprom_size_strap}; // R25
			sync_r <= meta_r; // R25
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// Bus busy monitor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_busy_r <= 1'b1; // R2
			post_rst_r <= 1'b1;
			stop_seen_r <= 1'b0;
			free_cnt_r <= '0;
		end else if (ce) begin
			if (start_w) begin
				bus_busy_r <= 1'b1; // R1
				stop_seen_r <= 1'b0;
				free_cnt_r <= '0;
			end else if (stop_w) begin
				stop_seen_r <= 1'b1; // R1
				free_cnt_r <= '0;
			end else if (bus_busy_r) begin
				if (free_hit_w) begin
					bus_busy_r <= 1'b0; // R1 R2
					post_rst_r <= 1'b0;
					stop_seen_r <= 1'b0;
				end
				free_cnt_r <= (scl_s & sda_s) ? free_cnt_r + 1'b1 : '0;
			end
			if (post_rst_r && !mgmt_i2c_r && !start_w) begin
				bus_busy_r <= 1'b0; // R3
				post_rst_r <= 1'b0;
			end
		end
	end

	// Bit engine next state
	always_comb begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		bit_nxt = bit_r;
		cnt_nxt = cnt_r + 1'b1;
		sda_nxt = sda_drv_r;
		rx_nxt = rx_r;
		fail_nxt = fail_r;
		poll_rst = 1'b0;
		arb_rst = 1'b0;
		arb_won = 1'b0;
		job_end = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				cnt_nxt = '0;
				if (start_job_w) begin
					phase_nxt = PH_ADDR_CTRL;
					fail_nxt = 1'b0;
					arb_rst = 1'b1;
					state_nxt = ST_WAIT_FREE;
				end
			end
			ST_WAIT_FREE: begin
				cnt_nxt = '0;
				sda_nxt = 1'b0;
				if (arb_run_r && arb_cnt_r >= ARB_LIM) begin
					fail_nxt = 1'b1; // R12
					state_nxt = ST_DONE;
				end else if (!bus_busy_r) begin
					state_nxt = ST_ST_SETUP; // R4
				end
			end
			ST_ST_SETUP: begin
				if (!scl_s) begin
					cnt_nxt = '0;
				end else if (cnt_r >= HIGH_LIM) begin
					cnt_nxt = '0;
					sda_nxt = 1'b1;
					state_nxt = ST_ST_HOLD;
				end
			end
			ST_ST_HOLD: begin
				if (cnt_r >= HIGH_LIM) begin
					cnt_nxt = '0;
					bit_nxt = '0;
					state_nxt = (phase_r == PH_STANDBY) ? ST_SP_LOW : ST_BIT_LOW;
				end
			end
			ST_BIT_LOW: begin
				if (cnt_r == HOLD_LIM) begin
					sda_nxt = tx_low_w; // R23
				end
				if (cnt_r >= LOW_LIM) begin
					cnt_nxt = '0;
					state_nxt = ST_BIT_REL; // R5
				end
			end
			ST_BIT_REL: begin
				if (scl_s) begin
					cnt_nxt = '0;
					if (tx_w && !tx_low_w && !sda_s) begin
						sda_nxt = 1'b0; // R6 R7
						phase_nxt = (phase_r == PH_POLL_CTRL) ? PH_POLL_CTRL : PH_ADDR_CTRL; // R9 R10
						state_nxt = ST_WAIT_FREE;
					end else begin
						rx_nxt = {rx_r[7:0], sda_s};
						arb_won = ctrl_ph_w && (bit_r == BIT_CTRL_LAST);
						state_nxt = ST_BIT_HIGH; // R5
					end
				end else if (cnt_r >= ACK_LIM) begin
					fail_nxt = 1'b1; // R18
					sda_nxt = 1'b0;
					state_nxt = ST_DONE;
				end
			end
			ST_BIT_HIGH: begin
				if (!scl_s || cnt_r >= HIGH_LIM) begin
					cnt_nxt = '0; // R5
					bit_nxt = '0;
					if (bit_r < BIT_ACK) begin
						bit_nxt = bit_r + 1'b1;
						state_nxt = ST_BIT_LOW;
					end else if (phase_r == PH_RD_DATA || phase_r == PH_STANDBY) begin
						state_nxt = ST_SP_LOW;
					end else if (rx_r[0]) begin
						fail_nxt = (phase_r != PH_POLL_CTRL); // R18
						state_nxt = ST_SP_LOW;
					end else begin
						state_nxt = ST_BIT_LOW;
						unique case (phase_r)
							PH_ADDR_CTRL: phase_nxt = two_byte_r ? PH_ADDR_HI : PH_ADDR_LO;
							PH_ADDR_HI: phase_nxt = PH_ADDR_LO;
							PH_ADDR_LO: begin
								phase_nxt = job_rd_r ? PH_RD_CTRL : PH_WR_DATA;
								state_nxt = job_rd_r ? ST_RS_LOW : ST_BIT_LOW;
							end
							PH_RD_CTRL: phase_nxt = PH_RD_DATA;
							PH_WR_DATA: state_nxt = ST_SP_LOW;
							PH_POLL_CTRL: begin
								phase_nxt = PH_STANDBY;
								state_nxt = ST_RS_LOW;
							end
							PH_RD_DATA, PH_STANDBY: state_nxt = ST_SP_LOW;
						endcase
					end
				end
			end
			ST_RS_LOW: begin
				if (cnt_r == HOLD_LIM) begin
					sda_nxt = 1'b0;
				end
				if (cnt_r >= LOW_LIM) begin
					cnt_nxt = '0;
					state_nxt = ST_ST_SETUP;
				end
			end
			ST_SP_LOW: begin
				if (cnt_r == HOLD_LIM) begin
					sda_nxt = 1'b1;
				end
				if (cnt_r >= LOW_LIM) begin
					cnt_nxt = '0;
					state_nxt = ST_SP_REL;
				end
			end
			ST_SP_REL: begin
				if (scl_s) begin
					cnt_nxt = '0;
					state_nxt = ST_SP_HIGH;
				end else if (cnt_r >= ACK_LIM) begin
					fail_nxt = 1'b1; // R18
					sda_nxt = 1'b0;
					state_nxt = ST_DONE;
				end
			end
			ST_SP_HIGH: begin
				if (cnt_r >= HIGH_LIM) begin
					cnt_nxt = '0;
					sda_nxt = 1'b0;
					state_nxt = ST_SP_END;
				end
			end
			ST_SP_END: begin
				cnt_nxt = '0;
				if (fail_r || phase_r == PH_RD_DATA || phase_r == PH_STANDBY) begin
					state_nxt = ST_DONE;
				end else if (phase_r == PH_WR_DATA) begin
					phase_nxt = PH_POLL_CTRL;
					poll_rst = 1'b1;
					arb_rst = 1'b1; // R12
					state_nxt = ST_WAIT_FREE;
				end else if (poll_cnt_r >= ACK_LIM) begin
					fail_nxt = 1'b1; // R11 R18
					state_nxt = ST_DONE;
				end else begin
					state_nxt = ST_WAIT_FREE;
				end
			end
			ST_DONE: begin
				cnt_nxt = '0;
				job_end = 1'b1;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Bit engine registers and pin drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			phase_r <= PH_ADDR_CTRL;
			bit_r <= '0;
			cnt_r <= '0;
			rx_r <= '0;
			fail_r <= 1'b0;
			sda_drv_r <= 1'b0;
			scl_drv_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			bit_r <= bit_nxt;
			cnt_r <= cnt_nxt;
			rx_r <= rx_nxt;
			fail_r <= fail_nxt;
			sda_drv_r <= sda_nxt;
			scl_drv_r <= (state_nxt == ST_BIT_LOW) || (state_nxt == ST_RS_LOW) ||
				(state_nxt == ST_SP_LOW);
		end
	end

	// Arbitration and write-completion timers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb_run_r <= 1'b0;
			arb_cnt_r <= '0;
			poll_cnt_r <= '0;
		end else if (ce) begin
			if (arb_rst) begin
				arb_run_r <= 1'b1; // R12
				arb_cnt_r <= '0;
			end else if (arb_won || job_end) begin
				arb_run_r <= 1'b0;
			end else if (arb_run_r && arb_cnt_r < ARB_LIM) begin
				arb_cnt_r <= arb_cnt_r + 1'b1;
			end
			if (poll_rst) begin
				poll_cnt_r <= '0; // R10
			end else if (poll_cnt_r < ACK_LIM) begin
				poll_cnt_r <= poll_cnt_r + 1'b1;
			end
		end
	end

	// Command registers and loader sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b1; // R19
			ld_active_r <= 1'b1; // R19
			ld_idx_r <= '0;
			tout_r <= 1'b0;
			cmd_r <= CMD_RST;
			addr_r <= '0;
			data_r <= '0;
			dig_pend_r <= 1'b0;
			mgmt_i2c_r <= MGMT_I2C_RST;
			job_rd_r <= 1'b1;
			job_addr_r <= '0;
			two_byte_r <= 1'b0;
			strap_flag_r <= '0;
			mac_r <= '0;
			strap_sh_r <= '0;
			strap_r <= '0;
			strap_load_r <= 1'b0;
		end else if (ce) begin
			strap_load_r <= 1'b0;
			if (wr_w && hit_cmd_w) begin
				if (pwdata[CMD_TOUT_BIT]) begin
					tout_r <= 1'b0;
				end
				if (!busy_r) begin
					busy_r <= pwdata[CMD_BUSY_BIT]; // R14 R15 R17
					cmd_r <= pwdata[CMD_CODE_LSB+:3];
					addr_r <= pwdata[ADDR_W-1:0];
				end
			end
			if (wr_w && hit_data_w && !busy_r) begin
				data_r <= pwdata[DATA_W-1:0]; // R14
			end
			if (wr_w && hit_hw_w) begin
				mgmt_i2c_r <= pwdata[HW_MGMT_BIT];
			end
			if (wr_w && hit_rst_w && pwdata[RST_DIG_BIT]) begin
				dig_pend_r <= 1'b1;
			end
			if (state_r == ST_IDLE && dig_pend_r) begin
				dig_pend_r <= 1'b0;
				busy_r <= 1'b1; // R19
				ld_active_r <= 1'b1;
				ld_idx_r <= '0;
			end else if (idle_w && busy_r && !ld_active_r && !cmd_ok_w) begin
				if (cmd_r == CMD_RELOAD) begin
					ld_active_r <= 1'b1; // R16 R13
					ld_idx_r <= '0;
				end else begin
					busy_r <= 1'b0;
				end
			end
			if (start_job_w) begin
				job_rd_r <= ld_active_r || (cmd_r == CMD_READ); // R13 R24
				job_addr_r <= ld_active_r ? ADDR_W'(ld_idx_r) : addr_r;
				two_byte_r <= size_s;
			end
			if (job_end && ld_active_r) begin
				if (fail_r || ld_idx_r == LD_LAST ||
						(ld_idx_r == LD_VALID && rx_r[8:1] != VALID_FLAG)) begin
					ld_active_r <= 1'b0; // R22
					busy_r <= 1'b0;
					strap_load_r <= 1'b1;
					if (strap_flag_r == VALID_FLAG && ld_idx_r == LD_LAST) begin
						strap_r <= strap_sh_r; // R21
					end
				end else begin
					ld_idx_r <= ld_idx_r + 1'b1;
				end
				if (ld_idx_r != LD_VALID && ld_idx_r <= LD_MAC_LAST) begin
					mac_r[8*(ld_idx_r-1'b1)+:8] <= rx_r[8:1]; // R21
				end
				if (ld_idx_r == LD_STRAP_FLAG) begin
					strap_flag_r <= rx_r[8:1];
				end
				if (ld_idx_r >= LD_STRAP_FIRST && ld_idx_r <= LD_STRAP_LAST) begin
					strap_sh_r[8*(ld_idx_r-LD_STRAP_FIRST)+:8] <= rx_r[8:1];
				end
			end else if (job_end) begin
				busy_r <= 1'b0; // R14 R15
				if (!fail_r && job_rd_r) begin
					data_r <= rx_r[8:1]; // R15
				end
			end
			if (job_end && fail_r) begin
				tout_r <= 1'b1; // R12 R18
			end
		end
	end

	// APB answer with one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			pready_r <= acc_w;
			pslverr_r <= acc_w & ~mapped_w;
			if (acc_w) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_w;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/eeprom_i2c_master_ctrl_test.sv
// Self-checking bench of the EEPROM I2C master controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_master_ctrl_test;
	import eic_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, nack_all, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, scl_oe, sda_oe, m_sda_oe;
	logic [47:0] mac_addr;
	wire scl, sda;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	// Open-drain lines with pull-ups
	assign scl = !scl_oe;
	assign sda = !(sda_oe || m_sda_oe);
	eic_top #(.IDLE_CYC_P(200), .ACK_CYC_P(20000), .ARB_CYC_P(50000)) DUT (
		.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.eeprom_size_strap(1'b0), .mac_addr(mac_addr), .strap_bits(), .strap_load()
	);
	eic_eeprom_model mem_model (.scl(scl), .sda(sda), .nack_all(nack_all), .sda_oe(m_sda_oe));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Run limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 160000) begin
			bad_count++;
			end_of_test;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One APB transfer, result in q and err
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		check({31'h0, pready}, 32'h0000_0001, "ready");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Poll command word until busy drops
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			repeat (1000) @(posedge pclk);
			apb(1'b0, OFS_CMD, 32'h0000_0000);
			n++;
		end while (q[CMD_BUSY_BIT] !== 1'b0 && n < 150);
		check(q & 32'h8000_0000, 32'h0000_0000, "busy cleared");
	endtask
	task automatic t_loader;
		apb(1'b0, OFS_CMD, 32'h0000_0000);
		check(q & 32'h8000_0000, 32'h8000_0000, "busy after reset");
		apb(1'b0, OFS_HWCFG, 32'h0000_0000);
		check(q & 32'h0000_0003, 32'h0000_0002, "ready in load");
		wait_done;
		check(q & 32'h0001_0000, 32'h0001_0000, "timeout on refusal");
		apb(1'b0, OFS_HWCFG, 32'h0000_0000);
		check(q & 32'h0000_0003, 32'h0000_0003, "ready after load");
		check(mac_addr[31:0], 32'h0000_0000, "mac untouched");
		apb(1'b0, 12'h010, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001, "unmapped error");
		check(q, 32'h0000_0000, "unmapped data");
		$display("loader test done");
	endtask
	task automatic t_reload;
		logic [11:0] a [2];
		logic [31:0] d [2];
		int n;
		a = '{OFS_CMD, OFS_RSTCTL};
		d = '{{1'b1, CMD_RELOAD, 28'h000_0000}, 32'h0000_0001};
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFS_CMD, 32'h0001_0000);
			apb(1'b1, a[i], d[i]);
			n = 0;
			do begin
				apb(1'b0, OFS_HWCFG, 32'h0000_0000);
				n++;
			end while (q[HW_READY_BIT] !== 1'b0 && n < 4);
			check(q & 32'h0000_0003, 32'h0000_0002, "ready in reload");
			wait_done;
			check(q & 32'h0001_0000, 32'h0001_0000, "reload timeout");
		end
		$display("reload test done");
	endtask
	task automatic t_write;
		nack_all <= 1'b0;
		apb(1'b1, OFS_CMD, 32'h0001_0000);
		apb(1'b0, OFS_CMD, 32'h0000_0000);
		check(q & 32'h8001_0000, 32'h0000_0000, "timeout cleared");
		apb(1'b1, OFS_DATA, 32'h0000_005A);
		apb(1'b1, OFS_CMD, {1'b1, CMD_WRITE, 12'h000, 16'h0021});
		apb(1'b1, OFS_DATA, 32'h0000_00FF);
		apb(1'b1, OFS_CMD, {1'b1, CMD_READ, 12'h000, 16'h0033});
		wait_done;
		check(q & 32'h8001_FFFF, 32'h0000_0021, "write status");
		apb(1'b0, OFS_DATA, 32'h0000_0000);
		check(q & 32'h0000_00FF, 32'h0000_005A, "data kept");
		check({24'h00_0000, mem_model.mem[8'h21]}, 32'h0000_005A, "stored byte");
		check({28'h000_0000, mem_model.ctrl_r[7:4]}, {28'h000_0000, CTRL_CODE}, "code");
		$display("write test done");
	endtask
	task automatic t_read;
		apb(1'b1, OFS_CMD, {1'b1, CMD_READ, 12'h000, 16'h0044});
		wait_done;
		check(q & 32'h8001_0000, 32'h0000_0000, "read status");
		apb(1'b0, OFS_DATA, 32'h0000_0000);
		check(q & 32'h0000_00FF, 32'h0000_00BB, "read byte");
		$display("read test done");
	endtask
	task automatic end_of_test;
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		nack_all = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_loader;
		t_reload;
		t_write;
		t_read;
		end_of_test;
	end
endmodule
bind eic_top eic_assertions #(.IDLE_CYC_P(IDLE_CYC_P)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.scl_i(scl_i), .sda_i(sda_i), .scl_oe(scl_oe), .sda_oe(sda_oe)
);
`default_nettype wire

// File: testbench/eic_assertions.sv
// Port-level checker of the EEPROM I2C master controller
`timescale 1ns/1ps
`default_nettype none
module eic_assertions #(
	parameter int unsigned IDLE_CYC_P = 200
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Two-wire bus
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_oe,
	input wire logic sda_oe
);
	logic [11:0] low_r, high_r, idle_r, low_nxt, high_nxt, idle_nxt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	function automatic logic [11:0] inc(input logic [11:0] v);
		return (v == 12'hFFF) ? v : v + 12'h001;
	endfunction
	// Run lengths of own clock pull, clock high and idle bus
	assign low_nxt = scl_oe ? inc(low_r) : 12'h000;
	assign high_nxt = scl_i ? inc(high_r) : 12'h000;
	assign idle_nxt = (scl_i && sda_i) ? inc(idle_r) : 12'h000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_r <= 12'h000;
			high_r <= 12'h000;
			idle_r <= 12'h000;
		end else begin
			low_r <= low_nxt;
			high_r <= high_nxt;
			idle_r <= idle_nxt;
		end
	end
	// Access phases of one transfer
	sequence access_first;
		psel && penable && !pready;
	endsequence
	sequence answer_once;
		pready ##1 !pready;
	endsequence
	one_wait_a: assert property (access_first |=> answer_once)
		else $error("access not answered after one wait state");
	setup_quiet_a: assert property (psel && !penable |=> !pready)
		else $error("ready raised in setup cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
		else $error("read data on a write");
	decode_err_a: assert property (pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0))
		else $error("error flag against decode");
	clock_low_a: assert property ($fell(scl_oe) |-> low_r >= 12'h1F4)
		else $error("clock released too early");
	clock_high_a: assert property ($rose(scl_oe) && scl_i |-> high_r >= 12'h1F4)
		else $error("clock pulled before high time");
	bus_free_a: assert property ($rose(sda_oe) && scl_i |-> {20'h0_0000, idle_r} >= IDLE_CYC_P)
		else $error("start on a busy bus");
endmodule
`default_nettype wire

// File: testbench/eic_eeprom_model.sv
// Behavioural serial EEPROM on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module eic_eeprom_model (
	// Resolved bus lines
	input wire logic scl,
	input wire logic sda,
	// Refuse every control byte
	input wire logic nack_all,
	// High pulls the data line low
	output logic sda_oe
);
	logic [7:0] mem [0:255];
	logic [7:0] sh, ptr, ctrl_r, dat;
	logic rd, ack, rd_act, wrote, busy;
	int nbit, nbyte;
	// Contents differ from their addresses
	initial begin
		sda_oe = 1'b0;
		{rd, ack, rd_act, wrote, busy} = 5'h00;
		{nbit, nbyte} = 64'h0;
		foreach (mem[i]) mem[i] = ~i[7:0];
	end
	// Start resets the byte framing
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			nbit = 0;
			nbyte = 0;
			rd_act = 1'b0;
		end
	end
	// Stop after data begins the internal write
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			busy = busy | wrote;
			wrote = 1'b0;
		end
	end
	// Shift master bits on the rising clock
	always @(posedge scl) begin
		if (nbit < 8) sh = {sh[6:0], sda};
		nbit++;
	end
	// Acknowledge or drive data while clock is low
	always @(negedge scl) begin
		if (nbit == 8 && !rd_act) begin
			if (nbyte == 0) begin
				ctrl_r = sh;
				rd = sh[0];
				ack = !nack_all && !busy && sh[7:4] == 4'hA;
				busy = 1'b0;
			end else if (nbyte == 1) begin
				ptr = sh;
			end else begin
				mem[ptr] = sh;
				wrote = 1'b1;
			end
			nbyte++;
			sda_oe <= ack;
		end else if (nbit == 9) begin
			nbit = 0;
			rd_act = !rd_act && rd && ack;
			dat = mem[ptr];
			sda_oe <= rd_act && !dat[7];
		end else begin
			sda_oe <= rd_act && nbit < 8 && !dat[7 - nbit];
		end
	end
endmodule
`default_nettype wire
